// *** inc/wws_pkg.sv ***
package wws_pkg;
    // Clock rate and time units
    localparam longint CLK_HZ = 40000000;
    // Watchdog period, in microseconds
    localparam longint WATCHDOG_PERIOD_US = 100000;
    // One tick is a fortieth of the watchdog period
    localparam int TICK_DIV = 40;
    // Cycles in one tick (2.5 ms at 40 MHz)
    localparam longint TICK_CYCLES_L =
        (CLK_HZ * WATCHDOG_PERIOD_US) / (TICK_DIV * 1000000);
    localparam int TICK_CYCLES = int'(TICK_CYCLES_L);
    // Span lengths in ticks
    localparam logic [5:0] CLOSED_SPAN_TICKS = 6'h20;
    localparam logic [5:0] OPEN_SPAN_TICKS = 6'h10;
    localparam logic [5:0] KICK_FAIL_PULSE_TICKS = 6'h01;
    localparam logic [5:0] HOLD_TICKS = 6'h28;
    // Comparator low filter time in nanoseconds (5 us)
    localparam longint LOW_FILTER_NS = 5000;
    localparam int LOW_FILTER_CYCLES =
        int'((LOW_FILTER_NS * CLK_HZ) / 1000000000);
    // Good services needed before enable
    localparam logic [1:0] GOOD_KICKS_NEEDED = 2'h3;
    // Reset values
    localparam logic [21:0] CYC_RESET = 22'h000000;
    localparam logic [5:0] TICK_RESET = 6'h00;
    localparam logic [1:0] GOOD_RESET = 2'h0;
    localparam logic [7:0] FILT_RESET = 8'h00;

    // Supervisor states
    typedef enum logic [2:0] {
        WWS_POWER_DOWN = 3'b000,
        WWS_HOLD = 3'b001,
        WWS_CLOSED = 3'b010,
        WWS_OPEN = 3'b011,
        WWS_FAIL_PULSE = 3'b100
    } wws_state_t;
endpackage : wws_pkg

// *** design/wws_supervisor.sv ***
// Summary of operation
// - Missed open window gives one-tick reset pulse
// - Early kick resets, restarts at closed window
// - No kicks repeat closed, open, pulse cycle
// - Repeat ends on open-window kick or low voltage
// - Voltage good starts hold, reset held low
// - Kicks ignored during hold delay
// - Hold end releases reset, closed window starts
// - Open-window kick restarts timer, no reset
// - Voltage low over 5 us forces reset
// - After low voltage, kicks wait for power-up
// - Enable inactive whenever reset is asserted
// - Enable active after three good kicks
// - Closed window 32 ticks after each restart
// - Open window 16 ticks after closed window
// - Hold delay equals watchdog period, 40 ticks
// The supervisor sits between a host processor and the system it resets.
// Every span is counted in ticks of one prescaler, so the closed window,
// the open window, the fail pulse and the power-up hold keep the same
// ratios whatever the tick length is.
// Both pins are asynchronous and pass two flip-flops before use; the
// reaction to a kick or to voltage good therefore lags it by two to three clocks.
module wws_supervisor
    import wws_pkg::*;
#(
    // Cycles in one tick; shorter values only shrink the time scale
    parameter int TICK_LEN = TICK_CYCLES
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_kick_input_n,
    input wire logic i_monitored_voltage_level,
    output logic o_supervisor_rst_out_n,
    output logic o_enable_n
);

    // Pin synchronisers
    logic kick_s1_r;
    logic kick_s2_r;
    logic kick_d_r;
    logic volt_s1_r;
    logic volt_s2_r;
    // Timebase and state
    logic [21:0] cyc_r;
    logic tick;
    logic [5:0] ticks_r;
    wws_state_t state_r;
    wws_state_t state_nxt;
    logic [7:0] low_cnt_r;
    logic volt_low;
    logic kick_fall;
    logic [1:0] good_r;
    logic restart;
    logic good_kick;

    // Two-flop synchronisers for both pins
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            kick_s1_r <= 1'b1;
            kick_s2_r <= 1'b1;
            kick_d_r <= 1'b1;
            volt_s1_r <= 1'b0;
            volt_s2_r <= 1'b0;
        end else begin
            kick_s1_r <= i_kick_input_n;
            kick_s2_r <= kick_s1_r;
            kick_d_r <= kick_s2_r;
            volt_s1_r <= i_monitored_voltage_level;
            volt_s2_r <= volt_s1_r;
        end
    end

    // Kick is a falling edge of the synchronised pin
    // The delay flop resets high, like the idle pin, so that leaving
    // reset never looks like a falling edge
    assign kick_fall = kick_d_r & ~kick_s2_r;

    // Low-voltage filter: must stay low over 5 us
    // A short dip restarts the count, so noise on the comparator flag
    // cannot throw the system into a power-down reset
    // The count saturates, keeping the override active while low
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_cnt_r <= FILT_RESET;
        end else if (volt_s2_r) begin
            low_cnt_r <= FILT_RESET;
        end else if (low_cnt_r != 8'(LOW_FILTER_CYCLES)) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    assign volt_low = (low_cnt_r == 8'(LOW_FILTER_CYCLES));

    // Restart timebase whenever the state changes
    // Each span therefore starts on a fresh prescaler count, and a kick
    // late in a tick does not shorten the following window
    assign restart = (state_nxt != state_r);

    // Prescaler: one tick per fortieth of the period
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cyc_r <= CYC_RESET;
        end else if (restart || tick) begin
            cyc_r <= CYC_RESET;
        end else begin
            cyc_r <= cyc_r + 22'h000001;
        end
    end
    // The prescaler wraps on the tick itself
    assign tick = (cyc_r == 22'(TICK_LEN - 1));

    // Tick counter within the current span
    // Six bits cover the longest span, the forty-tick hold delay
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ticks_r <= TICK_RESET;
        end else if (restart) begin
            ticks_r <= TICK_RESET;
        end else if (tick) begin
            ticks_r <= ticks_r + 6'h01;
        end
    end

    // A kick in the open window counts as good service
    // A kick in the last cycle of the open window still counts, since
    // the kick branch has priority over the timeout branch below
    assign good_kick = (state_r == WWS_OPEN) && kick_fall;

    // Next-state logic
    // Power-down and hold ignore the kick pin entirely
    // Closed window: any kick is a fault and gives a fail pulse
    // Open window: a kick restarts, a timeout gives a fail pulse
    // Fail pulse: one tick, then a fresh closed window
    // The low-voltage override is applied last so that it wins
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            WWS_POWER_DOWN: begin
                // Voltage good starts hold delay
                if (volt_s2_r) begin
                    state_nxt = WWS_HOLD;
                end
            end
            WWS_HOLD: begin
                // Kicks ignored here
                if (tick && ticks_r == HOLD_TICKS - 6'h01) begin
                    state_nxt = WWS_CLOSED;
                end
            end
            WWS_CLOSED: begin
                if (kick_fall) begin
                    state_nxt = WWS_FAIL_PULSE;
                end else if (tick &&
                    ticks_r == CLOSED_SPAN_TICKS - 6'h01) begin
                    state_nxt = WWS_OPEN;
                end
            end
            WWS_OPEN: begin
                if (kick_fall) begin
                    state_nxt = WWS_CLOSED;
                end else if (tick &&
                    ticks_r == OPEN_SPAN_TICKS - 6'h01) begin
                    state_nxt = WWS_FAIL_PULSE;
                end
            end
            WWS_FAIL_PULSE: begin
                // Pulse done, new cycle from a closed window
                if (tick &&
                    ticks_r == KICK_FAIL_PULSE_TICKS - 6'h01) begin
                    state_nxt = WWS_CLOSED;
                end
            end
            default: begin
                state_nxt = WWS_POWER_DOWN;
            end
        endcase
        // Low voltage overrides everything
        if (volt_low) begin
            state_nxt = WWS_POWER_DOWN;
        end
    end

    // State register
    // Reset enters power-down, where the reset output is held low
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= WWS_POWER_DOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Consecutive good-service counter, saturating
    // Clearing has priority over counting: entering any reset state
    // restarts qualification from zero, whatever the cause
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            good_r <= GOOD_RESET;
        end else if (state_nxt == WWS_POWER_DOWN ||
            state_nxt == WWS_HOLD || state_nxt == WWS_FAIL_PULSE) begin
            good_r <= GOOD_RESET;
        end else if (good_kick && good_r != GOOD_KICKS_NEEDED) begin
            good_r <= good_r + 2'h1;
        end
    end

    // Registered outputs; reset low and enable high while reset states are next
    // Both outputs come from flops fed by the next state, so they
    // change on the same edge as the state and never glitch
    // Enable falls on the edge of the third good kick
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_supervisor_rst_out_n <= 1'b0;
            o_enable_n <= 1'b1;
        end else begin
            o_supervisor_rst_out_n <= (state_nxt == WWS_CLOSED) ||
                (state_nxt == WWS_OPEN);
            o_enable_n <= !(((state_nxt == WWS_CLOSED) ||
                (state_nxt == WWS_OPEN)) &&
                (good_r == GOOD_KICKS_NEEDED ||
                (good_kick && good_r == GOOD_KICKS_NEEDED - 2'h1)));
        end
    end

endmodule : wws_supervisor

// *** tb/wws_supervisor_sva.sv ***
module wws_supervisor_sva
    import wws_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES // Cycles in one tick
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_kick_input_n,
    input wire logic i_monitored_voltage_level,
    input wire logic o_supervisor_rst_out_n,
    input wire logic o_enable_n
);
    wire logic rst_n = o_supervisor_rst_out_n; // Short alias
    wire logic volt = i_monitored_voltage_level; // Short alias
    int good_r; // Cycles of steady voltage good
    int low_r; // Cycles of steady voltage low
    int age_r; // Cycles since the last kick edge
    // Voltage good run length
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) good_r <= 0;
        else good_r <= volt ? good_r + 1 : 0;
    end
    // Voltage low run length
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) low_r <= 0;
        else low_r <= volt ? 0 : low_r + 1;
    end
    // Age of the last kick edge, saturating
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) age_r <= 99;
        else if ($fell(i_kick_input_n)) age_r <= 0;
        else if (age_r < 99) age_r <= age_r + 1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // Reset output stays low for a while
    sequence s_held;
        !rst_n [*8];
    endsequence
    AST_EN_OFF_IN_RST: assert property (!rst_n |-> o_enable_n)
        else $error("enable active during reset");
    AST_EN_STAYS_OFF: assert property (
        o_enable_n && !rst_n |=> o_enable_n)
        else $error("enable fell while reset low");
    AST_HOLD_KEEPS_RST: assert property (
        $rose(volt) && !rst_n |=> s_held)
        else $error("reset released at voltage good");
    AST_HOLD_FULL: assert property (
        $rose(rst_n) |-> good_r >= HOLD_TICKS * TICK_LEN)
        else $error("reset released before hold end");
    AST_LOW_FORCES: assert property (
        low_r > 205 |-> !rst_n && o_enable_n)
        else $error("low voltage not forcing reset");
    AST_PULSE_MIN: assert property (
        $fell(rst_n) |=> s_held)
        else $error("reset pulse too short");
    AST_EN_NEEDS_KICK: assert property (
        $fell(o_enable_n) |-> age_r <= 8 && rst_n)
        else $error("enable without a good kick");
    AST_HOLD_IGNORES: assert property (
        $fell(i_kick_input_n) && !rst_n && good_r > 9 &&
        good_r < HOLD_TICKS * TICK_LEN - 8 |=> s_held)
        else $error("kick acted during hold");
    AST_LOW_IGNORES: assert property (
        low_r > 205 && $fell(i_kick_input_n) |=> !rst_n [*4])
        else $error("kick acted after low voltage");
endmodule : wws_supervisor_sva

bind wws_supervisor wws_supervisor_sva #(.TICK_LEN(TICK_LEN)) u_sva (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_kick_input_n(i_kick_input_n),
    .i_monitored_voltage_level(i_monitored_voltage_level),
    .o_supervisor_rst_out_n(o_supervisor_rst_out_n),
    .o_enable_n(o_enable_n));

// *** tb/wws_host_model.sv ***
module wws_host_model (
    input wire logic i_clock,
    input wire logic i_kick_req,
    output logic o_kick_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int left_r = 0; // Cycles of low pin still to go
    // A request starts an 8-cycle low pulse, above the minimum width
    always @(posedge i_clock) begin
        if (i_kick_req) left_r <= 8;
        else if (left_r > 0) left_r <= left_r - 1;
    end
    // Pin changes only at the falling edge, idle high
    always @(negedge i_clock) o_kick_input_n <= !(left_r > 0);
endmodule : wws_host_model

// *** tb/wws_supervisor_tb.sv ***
module wws_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0; // Bench clock
    logic i_reset_n = 1'b0; // Bench reset
    logic kick_req = 1'b0; // Request to the host model
    logic volt = 1'b0; // Comparator flag
    logic kick_n; // Kick pin from the host model
    logic rst_n; // Reset output seen
    logic en_n; // Enable output seen
    int num_errors = 0;
    int n_compared = 0;
    localparam int TICK_LEN = 200; // Short tick keeps the run brief
    wws_host_model host (.i_clock(i_clock), .i_kick_req(kick_req),
        .o_kick_input_n(kick_n));
    wws_supervisor #(.TICK_LEN(TICK_LEN)) uut (.i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_kick_input_n(kick_n), .i_monitored_voltage_level(volt),
        .o_supervisor_rst_out_n(rst_n), .o_enable_n(en_n));
    // Clock at 40 MHz
    initial forever #12.5 i_clock = ~i_clock;
    // Compare both outputs with the expected levels
    task automatic check(input logic er, input logic ee);
        n_compared += 2;
        if (rst_n !== er) begin
            num_errors++;
            $display("CHECK FAILED rst_out exp %b got %b", er, rst_n);
        end
        if (en_n !== ee) begin
            num_errors++;
            $display("CHECK FAILED enable exp %b got %b", ee, en_n);
        end
    endtask : check
    // One clear pulse through the host model
    task automatic kick;
        @(negedge i_clock) kick_req = 1'b1;
        @(negedge i_clock) kick_req = 1'b0;
        repeat (12) @(negedge i_clock);
    endtask : kick
    // Wait a number of falling edges
    task automatic idle(input int n);
        repeat (n) @(negedge i_clock);
    endtask : idle
    // Wait, then kick; kick lands about w + 5 cycles later
    task automatic good(input int w);
        idle(w);
        kick();
    endtask : good
    // Voltage good: reset held for 40 ticks, kicks have no effect
    task automatic t_hold;
        @(negedge i_clock) volt = 1'b1;
        idle(20);
        kick();
        idle(7860);
        check(1'b0, 1'b1);
        idle(200);
        check(1'b1, 1'b1);
    endtask : t_hold
    // No kicks: closed and open windows run out into a fail pulse
    task automatic t_timeout;
        idle(9459);
        check(1'b1, 1'b1);
        idle(150);
        check(1'b0, 1'b1);
        idle(150);
        check(1'b1, 1'b1);
    endtask : t_timeout
    // Three open-window kicks restart the timer and qualify enable
    task automatic t_good;
        good(6445);
        check(1'b1, 1'b1);
        good(6490);
        check(1'b1, 1'b1);
        good(6490);
        check(1'b1, 1'b0);
    endtask : t_good
    // Early kick gives a fail pulse and drops qualification
    task automatic t_early;
        kick();
        check(1'b0, 1'b1);
        idle(200);
        check(1'b1, 1'b1);
    endtask : t_early
    // Long low voltage forces reset; kicks then ignored
    task automatic t_low;
        repeat (300) @(negedge i_clock) volt = 1'b0;
        check(1'b0, 1'b1);
        kick();
        check(1'b0, 1'b1);
    endtask : t_low
    task automatic conclude;
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clock);
        @(negedge i_clock) i_reset_n = 1'b1;
        check(1'b0, 1'b1);
        t_hold();
        t_timeout();
        t_good();
        t_early();
        t_low();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        #1500000;
        num_errors++;
        conclude();
    end
endmodule : wws_supervisor_tb
